// File: rtl/ufic_ctrl.sv
// What this block does
// - A write with the transmit clear bit set empties the transmit FIFO for one cycle and the bit falls back to 0.
// - A write with the receive clear bit set empties the receive FIFO for one cycle and the bit falls back to 0.
// - Bit 0 of fifo_ctrl enables both FIFOs when 1 and is 0 after reset.
// - The other fifo_ctrl bits are taken only when bit 0 is written as 1 in the same write.
// - Trigger field codes 00, 01, 10, 11 select 1, 4, 8 and 14 characters.
// - An irq_status read returns the reported interrupt, latched as the highest pending level while psel is low, modem status being level 4 with code 000000.
// - While one interrupt is reported and unserviced no other source is taken.
// - A read of irq_status clears only the reported interrupt, so lower ones show next.
// - Receiver line status is level 1 with code 000110.
// - Receive data is level 2 with code 000100 and time-out with code 001100.
// - Transmit holding empty is level 3 with code 000010.
// - Bit 0 of irq_status is 0 while an interrupt is reported and 1 otherwise, 1 after reset.
// - Bits 7:6 of irq_status read 1 while the FIFOs are enabled, else 0.
// - Bits 5:4 of irq_status always read 0.
// - Bit 3 of fifo_ctrl selects DMA mode 1 when set, mode 0 by default.
// - With the FIFOs enabled the receive interrupt rises when the FIFO count equals the trigger level, otherwise when the count is not 0.
`timescale 1ns/1ps
`default_nettype none

module ufic_ctrl
   import ufic_pkg::*;
(
   input wire logic clk,
   input wire logic reset,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic lineErrPulse,
   input wire logic [4:0] rxFifoCount,
   input wire logic rxTimeoutPulse,
   input wire logic txHoldEmptyPulse,
   input wire logic modemChangePulse,
   output logic fifoEnable,
   output logic dmaMode,
   output logic [4:0] rxTriggerLevel,
   output logic txFifoClear,
   output logic rxFifoClear,
   output logic chanIrqReq,
   output logic irqOut
);

   // ----------------------------------------
   // State
   // ----------------------------------------
   typedef struct packed {
      logic fifoEn;
      logic dma;
      logic [1:0] trig;
      logic txClr;
      logic rxClr;
      logic pendLine;
      logic pendRx;
      logic pendTmo;
      logic pendThre;
      logic pendModem;
      ufic_cur_t cur;
      logic [3:0] srcEn;
      logic [3:0] evtSts;
      logic [3:0] evtMask;
      logic irqReq;
      logic [31:0] rdata;
   } ufic_state_t;

   ufic_state_t st_r;
   ufic_state_t st_nxt;

   // ----------------------------------------
   // Functions
   // ----------------------------------------
   function automatic logic [4:0] trig_level(input logic [1:0] sel);
      logic [4:0] lvl;
      lvl = UFIC_TRIG_L0;
      case (sel)
         2'b00: lvl = UFIC_TRIG_L0;
         2'b01: lvl = UFIC_TRIG_L1;
         2'b10: lvl = UFIC_TRIG_L2;
         default: lvl = UFIC_TRIG_L3;
      endcase
      return lvl;
   endfunction : trig_level

   function automatic logic [3:0] cur_code(input ufic_cur_t c);
      logic [3:0] code;
      code = UFIC_CODE_NONE;
      case (c)
         UFIC_CUR_LINE: code = UFIC_CODE_LINE;
         UFIC_CUR_RXDATA: code = UFIC_CODE_RXDATA;
         UFIC_CUR_RXTMO: code = UFIC_CODE_RXTMO;
         UFIC_CUR_THRE: code = UFIC_CODE_THRE;
         UFIC_CUR_MODEM: code = UFIC_CODE_MODEM;
         default: code = UFIC_CODE_NONE;
      endcase
      return code;
   endfunction : cur_code

   function automatic logic is_mapped(input logic [7:0] a);
      logic hit;
      hit = 1'b0;
      if (a == UFIC_FIFO_CTRL_OFS)
      begin
         hit = 1'b1;
      end
      else if (a == UFIC_IRQ_STATUS_OFS)
      begin
         hit = 1'b1;
      end
      else if (a == UFIC_SRC_EN_OFS)
      begin
         hit = 1'b1;
      end
      else if (a == UFIC_EVT_STS_OFS)
      begin
         hit = 1'b1;
      end
      else if (a == UFIC_EVT_MASK_OFS)
      begin
         hit = 1'b1;
      end
      return hit;
   endfunction : is_mapped

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   logic setupRd;
   logic accWr;
   logic accRd;
   logic [7:0] isrByte;
   logic [4:0] trigNow;
   logic rxHit;
   logic ovrEn;
   logic rxOn;

   always_comb
   begin
      st_nxt = st_r;
      setupRd = psel && !penable && !pwrite;
      accWr = psel && penable && pwrite && is_mapped(paddr);
      accRd = psel && penable && !pwrite && is_mapped(paddr);
      trigNow = trig_level(st_r.trig);
      isrByte = {st_r.fifoEn, st_r.fifoEn, 2'b00, cur_code(st_r.cur)};
      rxOn = st_r.srcEn[UFIC_SRC_RX];
      rxHit = st_r.fifoEn ? (rxFifoCount == trigNow)
         : (rxFifoCount != 5'h00);
      ovrEn = 1'b0;

      st_nxt.txClr = 1'b0;
      st_nxt.rxClr = 1'b0;

      // Register writes.
      if (accWr)
      begin
         if (paddr == UFIC_FIFO_CTRL_OFS)
         begin
            st_nxt.fifoEn = pwdata[UFIC_FC_EN_BIT];
            if (pwdata[UFIC_FC_EN_BIT])
            begin
               st_nxt.dma = pwdata[UFIC_FC_DMA_BIT];
               st_nxt.trig = pwdata[UFIC_FC_TRIG_LSB +: 2];
               st_nxt.txClr = pwdata[UFIC_FC_TXCLR_BIT];
               st_nxt.rxClr = pwdata[UFIC_FC_RXCLR_BIT];
            end
            else
            begin
               ovrEn = (pwdata[7:1] != 7'h00);
            end
         end
         else if (paddr == UFIC_SRC_EN_OFS)
         begin
            st_nxt.srcEn = pwdata[3:0];
         end
         else if (paddr == UFIC_EVT_MASK_OFS)
         begin
            st_nxt.evtMask = pwdata[3:0];
         end
      end

      // Pending sources; a new event wins over a read clear.
      if (accRd && paddr == UFIC_IRQ_STATUS_OFS)
      begin
         case (st_r.cur)
            UFIC_CUR_LINE: st_nxt.pendLine = 1'b0;
            UFIC_CUR_RXDATA: st_nxt.pendRx = 1'b0;
            UFIC_CUR_RXTMO: st_nxt.pendTmo = 1'b0;
            UFIC_CUR_THRE: st_nxt.pendThre = 1'b0;
            UFIC_CUR_MODEM: st_nxt.pendModem = 1'b0;
            default: st_nxt.pendLine = st_r.pendLine;
         endcase
      end
      if (rxFifoCount < trigNow && st_r.fifoEn)
      begin
         st_nxt.pendRx = 1'b0;
      end
      if (lineErrPulse && st_r.srcEn[UFIC_SRC_LINE])
      begin
         st_nxt.pendLine = 1'b1;
      end
      if (rxHit && rxOn)
      begin
         st_nxt.pendRx = 1'b1;
      end
      if (rxTimeoutPulse && rxOn)
      begin
         st_nxt.pendTmo = 1'b1;
      end
      if (txHoldEmptyPulse && st_r.srcEn[UFIC_SRC_THRE])
      begin
         st_nxt.pendThre = 1'b1;
      end
      if (modemChangePulse && st_r.srcEn[UFIC_SRC_MODEM])
      begin
         st_nxt.pendModem = 1'b1;
      end

      // Reported interrupt latch.
      case (st_r.cur)
         UFIC_CUR_NONE:
         begin
            if (psel)
            begin
               st_nxt.cur = UFIC_CUR_NONE;
            end
            else if (st_r.pendLine)
            begin
               st_nxt.cur = UFIC_CUR_LINE;
            end
            else if (st_r.pendRx)
            begin
               st_nxt.cur = UFIC_CUR_RXDATA;
            end
            else if (st_r.pendTmo)
            begin
               st_nxt.cur = UFIC_CUR_RXTMO;
            end
            else if (st_r.pendThre)
            begin
               st_nxt.cur = UFIC_CUR_THRE;
            end
            else if (st_r.pendModem)
            begin
               st_nxt.cur = UFIC_CUR_MODEM;
            end
         end
         default:
         begin
            if (accRd && paddr == UFIC_IRQ_STATUS_OFS)
            begin
               st_nxt.cur = UFIC_CUR_NONE;
            end
            else if (st_r.cur == UFIC_CUR_RXDATA && !st_nxt.pendRx)
            begin
               st_nxt.cur = UFIC_CUR_NONE;
            end
         end
      endcase

      st_nxt.irqReq = (st_nxt.cur != UFIC_CUR_NONE);

      // Event status, cleared by a read; a new event wins.
      if (accRd && paddr == UFIC_EVT_STS_OFS)
      begin
         st_nxt.evtSts = 4'h0;
      end
      if (st_nxt.txClr)
      begin
         st_nxt.evtSts[UFIC_EVT_TXCLR] = 1'b1;
      end
      if (st_nxt.rxClr)
      begin
         st_nxt.evtSts[UFIC_EVT_RXCLR] = 1'b1;
      end
      if (ovrEn)
      begin
         st_nxt.evtSts[UFIC_EVT_IGNORED] = 1'b1;
      end
      if (st_nxt.irqReq && !st_r.irqReq)
      begin
         st_nxt.evtSts[UFIC_EVT_IRQ] = 1'b1;
      end

      // Read data captured in the setup cycle.
      if (setupRd)
      begin
         st_nxt.rdata = 32'h0000_0000;
         if (paddr == UFIC_IRQ_STATUS_OFS)
         begin
            st_nxt.rdata = {24'h00_0000, isrByte};
         end
         else if (paddr == UFIC_SRC_EN_OFS)
         begin
            st_nxt.rdata = {28'h000_0000, st_r.srcEn};
         end
         else if (paddr == UFIC_EVT_STS_OFS)
         begin
            st_nxt.rdata = {28'h000_0000, st_r.evtSts};
         end
         else if (paddr == UFIC_EVT_MASK_OFS)
         begin
            st_nxt.rdata = {28'h000_0000, st_r.evtMask};
         end
      end
   end

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         st_r <= '0;
         st_r.cur <= UFIC_CUR_NONE;
         st_r.srcEn <= UFIC_SRC_EN_RST;
         st_r.evtMask <= UFIC_EVT_MASK_RST;
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign pready = psel && penable;
   assign pslverr = psel && penable && !is_mapped(paddr);
   assign prdata = st_r.rdata;
   assign fifoEnable = st_r.fifoEn;
   assign dmaMode = st_r.dma;
   assign rxTriggerLevel = trig_level(st_r.trig);
   assign txFifoClear = st_r.txClr;
   assign rxFifoClear = st_r.rxClr;
   assign chanIrqReq = st_r.irqReq;
   assign irqOut = |(st_r.evtSts & st_r.evtMask);

endmodule : ufic_ctrl

`default_nettype wire

// File: common/ufic_pkg.sv
package ufic_pkg;

   // ----------------------------------------
   // Register byte offsets
   // ----------------------------------------
   localparam logic [7:0] UFIC_FIFO_CTRL_OFS = 8'h00;
   localparam logic [7:0] UFIC_IRQ_STATUS_OFS = 8'h04;
   localparam logic [7:0] UFIC_SRC_EN_OFS = 8'h08;
   localparam logic [7:0] UFIC_EVT_STS_OFS = 8'h0C;
   localparam logic [7:0] UFIC_EVT_MASK_OFS = 8'h10;

   // ----------------------------------------
   // Field positions of fifo_ctrl
   // ----------------------------------------
   localparam int UFIC_FC_EN_BIT = 0;
   localparam int UFIC_FC_RXCLR_BIT = 1;
   localparam int UFIC_FC_TXCLR_BIT = 2;
   localparam int UFIC_FC_DMA_BIT = 3;
   localparam int UFIC_FC_TRIG_LSB = 6;

   // ----------------------------------------
   // Receive trigger levels
   // ----------------------------------------
   localparam logic [4:0] UFIC_TRIG_L0 = 5'h01;
   localparam logic [4:0] UFIC_TRIG_L1 = 5'h04;
   localparam logic [4:0] UFIC_TRIG_L2 = 5'h08;
   localparam logic [4:0] UFIC_TRIG_L3 = 5'h0E;

   // ----------------------------------------
   // irq_status bits 3:0 codes
   // ----------------------------------------
   localparam logic [3:0] UFIC_CODE_NONE = 4'h1;
   localparam logic [3:0] UFIC_CODE_LINE = 4'h6;
   localparam logic [3:0] UFIC_CODE_RXDATA = 4'h4;
   localparam logic [3:0] UFIC_CODE_RXTMO = 4'hC;
   localparam logic [3:0] UFIC_CODE_THRE = 4'h2;
   localparam logic [3:0] UFIC_CODE_MODEM = 4'h0;

   // ----------------------------------------
   // Source enable and event bit positions
   // ----------------------------------------
   localparam int UFIC_SRC_LINE = 0;
   localparam int UFIC_SRC_RX = 1;
   localparam int UFIC_SRC_THRE = 2;
   localparam int UFIC_SRC_MODEM = 3;
   localparam int UFIC_EVT_TXCLR = 0;
   localparam int UFIC_EVT_RXCLR = 1;
   localparam int UFIC_EVT_IGNORED = 2;
   localparam int UFIC_EVT_IRQ = 3;

   // ----------------------------------------
   // Reset values
   // ----------------------------------------
   localparam logic [3:0] UFIC_SRC_EN_RST = 4'h0;
   localparam logic [3:0] UFIC_EVT_MASK_RST = 4'h0;

   typedef enum logic [2:0] {
      UFIC_CUR_NONE = 3'b000,
      UFIC_CUR_LINE = 3'b001,
      UFIC_CUR_RXDATA = 3'b010,
      UFIC_CUR_RXTMO = 3'b011,
      UFIC_CUR_THRE = 3'b100,
      UFIC_CUR_MODEM = 3'b101
   } ufic_cur_t;

endpackage : ufic_pkg

// File: test/ufic_ctrl_chk.sv
`timescale 1ns/1ps
`default_nettype none
module ufic_ctrl_chk
   import ufic_pkg::*;
(
   input wire logic clk,
   input wire logic reset,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic fifoEnable,
   input wire logic dmaMode,
   input wire logic [4:0] rxTriggerLevel,
   input wire logic txFifoClear,
   input wire logic rxFifoClear,
   input wire logic chanIrqReq
);
   // ---
   // Access decode and expected trigger.
   // ---
   logic wr0;
   logic rd4;
   logic [4:0] trigExp;
   assign wr0 = psel && penable && pwrite && paddr == UFIC_FIFO_CTRL_OFS;
   assign rd4 = psel && penable && !pwrite && paddr == UFIC_IRQ_STATUS_OFS;
   always_comb
   begin
      case (pwdata[7:6])
         2'b00: trigExp = 5'h01;
         2'b01: trigExp = 5'h04;
         2'b10: trigExp = 5'h08;
         default: trigExp = 5'h0E;
      endcase
   end
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (reset);
   // ---
   // Properties.
   // ---
   // transmit clear pulse
   property p_txclr;
      wr0 && pwdata[0] && pwdata[2] |=> txFifoClear ##1 !txFifoClear;
   endproperty
   a_txclr: assert property (p_txclr)
      else $error("transmit clear pulse wrong");
   property p_rxclr;
      wr0 && pwdata[0] && pwdata[1] |=> rxFifoClear ##1 !rxFifoClear;
   endproperty
   a_rxclr: assert property (p_rxclr)
      else $error("receive clear pulse wrong");
   property p_en;
      wr0 |=> fifoEnable == $past(pwdata[0]);
   endproperty
   a_en: assert property (p_en)
      else $error("fifo enable wrong");
   property p_ign;
      wr0 && !pwdata[0] |=> $stable(dmaMode) && $stable(rxTriggerLevel)
         && !txFifoClear && !rxFifoClear;
   endproperty
   a_ign: assert property (p_ign)
      else $error("write without enable took effect");
   property p_trig;
      wr0 && pwdata[0] |=> rxTriggerLevel == $past(trigExp);
   endproperty
   a_trig: assert property (p_trig)
      else $error("trigger level wrong");
   property p_dma;
      wr0 && pwdata[0] |=> dmaMode == $past(pwdata[3]);
   endproperty
   a_dma: assert property (p_dma)
      else $error("dma mode wrong");
   property p_stat;
      rd4 |-> prdata[0] == !$past(chanIrqReq);
   endproperty
   a_stat: assert property (p_stat)
      else $error("status bit and request disagree");
   property p_fen;
      rd4 |-> prdata[7:4] == {$past(fifoEnable), $past(fifoEnable), 2'b00};
   endproperty
   a_fen: assert property (p_fen)
      else $error("status upper bits wrong");
   c_line: cover property (rd4 && prdata[3:0] == UFIC_CODE_LINE);
   c_modem: cover property (rd4 && prdata[3:0] == UFIC_CODE_MODEM);
   c_txclr: cover property (txFifoClear);
endmodule : ufic_ctrl_chk
bind ufic_ctrl ufic_ctrl_chk i_ufic_ctrl_chk (.clk, .reset, .psel, .penable,
   .pwrite, .paddr, .pwdata, .prdata, .fifoEnable, .dmaMode, .rxTriggerLevel,
   .txFifoClear, .rxFifoClear, .chanIrqReq);
`default_nettype wire

// File: test/ufic_fifo_model.sv
`timescale 1ns/1ps
`default_nettype none
module ufic_fifo_model
(
   input wire logic clk,
   input wire logic reset,
   input wire logic push,
   input wire logic rxFifoClear,
   input wire logic txFifoClear,
   output logic [4:0] rxFifoCount,
   output logic [7:0] txClears
);
   // ---
   // Receive fill count and transmit clear tally.
   // ---
   always_ff @(posedge clk)
   begin
      if (reset || rxFifoClear)
         rxFifoCount <= 5'h00;
      else if (push && rxFifoCount != 5'h10)
         rxFifoCount <= rxFifoCount + 5'h01;
      if (reset)
         txClears <= 8'h00;
      else if (txFifoClear)
         txClears <= txClears + 8'h01;
   end
endmodule : ufic_fifo_model
`default_nettype wire

// File: test/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top
   import ufic_pkg::*;
();
   // ---
   // Stimulus, tasks and scenarios.
   // ---
   logic clk, reset, psel, penable, pwrite, pready, pslverr, push, err;
   logic fifoEnable, dmaMode, txFifoClear, rxFifoClear, chanIrqReq, irqOut;
   logic [7:0] paddr, txClears;
   logic [31:0] pwdata, prdata, rd;
   logic [4:0] rxFifoCount, rxTriggerLevel;
   logic [3:0] src;
   logic [4:0] tl [4] = '{5'h01, 5'h04, 5'h08, 5'h0E};
   logic [7:0] codes [5] = '{8'hC6, 8'hCC, 8'hC2, 8'hC0, 8'hC1};
   int err_total, checks, cyc;
   ufic_ctrl i_ufic_ctrl (.clk, .reset, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .lineErrPulse(src[0]), .rxFifoCount,
      .rxTimeoutPulse(src[1]), .txHoldEmptyPulse(src[2]),
      .modemChangePulse(src[3]), .fifoEnable, .dmaMode, .rxTriggerLevel,
      .txFifoClear, .rxFifoClear, .chanIrqReq, .irqOut);
   ufic_fifo_model i_ufic_fifo_model (.clk, .reset, .push, .rxFifoClear,
      .txFifoClear, .rxFifoCount, .txClears);
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   task automatic test_done;
      $display("checks %0d errors %0d", checks, err_total);
      if (err_total == 0 && checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : test_done
   task automatic chk(input string nm, input logic [31:0] exp, got);
      checks++;
      if (got !== exp)
      begin
         err_total++;
         $display("ERROR %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask : tick
   task automatic apb(input logic wr, input logic [7:0] a,
      input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1)
         @(posedge clk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask : apb
   task automatic t_reset;
      apb(1'b0, UFIC_IRQ_STATUS_OFS, 32'h0);
      chk("irq_status", 32'h01, rd);
      apb(1'b0, 8'h14, 32'h0);
      chk("pslverr", 32'h1, {31'h0, err});
   endtask : t_reset
   task automatic t_fifo;
      apb(1'b1, UFIC_FIFO_CTRL_OFS, 32'hCE);
      chk("trigger", 32'h01, {27'h0, rxTriggerLevel});
      chk("txClears", 32'h0, {24'h0, txClears});
      for (int i = 0; i < 4; i++)
      begin
         apb(1'b1, UFIC_FIFO_CTRL_OFS, 32'({i[1:0], 6'h09}));
         chk("trigger", {27'h0, tl[i]}, {27'h0, rxTriggerLevel});
         chk("dmaMode", 32'h1, {31'h0, dmaMode});
         chk("fifoEnable", 32'h1, {31'h0, fifoEnable});
      end
      push <= 1'b1;
      tick(3);
      push <= 1'b0;
      apb(1'b1, UFIC_FIFO_CTRL_OFS, 32'h07);
      tick(1);
      chk("dmaMode", 32'h0, {31'h0, dmaMode});
      chk("rxFifoCount", 32'h0, {27'h0, rxFifoCount});
      chk("txClears", 32'h1, {24'h0, txClears});
      apb(1'b0, UFIC_IRQ_STATUS_OFS, 32'h0);
      chk("irq_status", 32'hC1, rd);
   endtask : t_fifo
   task automatic t_prio;
      apb(1'b1, UFIC_SRC_EN_OFS, 32'h0F);
      src <= 4'hF;
      tick(1);
      src <= 4'h0;
      tick(3);
      chk("chanIrqReq", 32'h1, {31'h0, chanIrqReq});
      for (int i = 0; i < 5; i++)
      begin
         apb(1'b0, UFIC_IRQ_STATUS_OFS, 32'h0);
         chk("irq_status", {24'h0, codes[i]}, rd);
         tick(3);
      end
      push <= 1'b1;
      tick(1);
      push <= 1'b0;
      tick(3);
      apb(1'b0, UFIC_IRQ_STATUS_OFS, 32'h0);
      chk("irq_status", 32'hC4, rd);
      apb(1'b1, UFIC_FIFO_CTRL_OFS, 32'h03);
      tick(3);
      apb(1'b0, UFIC_IRQ_STATUS_OFS, 32'h0);
      chk("irq_status", 32'hC1, rd);
      chk("chanIrqReq", 32'h0, {31'h0, chanIrqReq});
   endtask : t_prio
   task automatic t_irq;
      apb(1'b0, UFIC_EVT_STS_OFS, 32'h0);
      apb(1'b1, UFIC_FIFO_CTRL_OFS, 32'h05);
      tick(2);
      chk("irqOut masked", 32'h0, {31'h0, irqOut});
      apb(1'b1, UFIC_EVT_MASK_OFS, 32'h1);
      chk("irqOut", 32'h1, {31'h0, irqOut});
      apb(1'b0, UFIC_EVT_STS_OFS, 32'h0);
      chk("evt_sts", 32'h1, {31'h0, rd[0]});
      chk("irqOut cleared", 32'h0, {31'h0, irqOut});
   endtask : t_irq
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 5000)
      begin
         err_total++;
         test_done();
      end
   end
   initial
   begin
      reset = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      push = 1'b0;
      src = 4'h0;
      repeat (6) @(posedge clk);
      reset <= 1'b0;
      @(posedge clk);
      t_reset();
      t_fifo();
      t_prio();
      t_irq();
      test_done();
   end
endmodule : tb_top
`default_nettype wire
